// file: src/clock_power_down_and_cpu_stop.sv
// Purpose: Output gating for a clock generator: power good / power down and CPU clock halt.
// Assumes: Pins come from another domain; enable and stoppable masks come from local logic.
// Notes: One internal CPU clock drives every CPU pair; pairs differ only in gating.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Shared pin is power good, then power down
// - Power-down pin synchronised before synthesizer shutdown
// - Power-down release wakes clocks through synchroniser
// - Outputs held low before oscillator turns off
// - Two low samples; SE park on falling
// - Power-down: SE low or hi-z; diff low
// - Stable clocks under 1.8 ms after release
// - Stopped diff outputs biased high under 300 us
// - Outputs enabled within few cycles of lock
// - Halt touches only stoppable CPU outputs
// - Halt after two complement samples, 2-6 periods
// - Parked CPU output: true high, complement low
// - Halted outputs restart synchronous to running clock
// - Restart makes no short or stretched pulse
// - Restart within two CPU clock cycles
// - SE keep running; disabled outputs driven low
module clock_power_down_and_cpu_stop #(
  parameter int N_CPU = 2,
  parameter int N_SE = 2,
  parameter int LOCK_CYCLES = clk_gate_pkg::LOCK_CYCLES,
  parameter int BIAS_CYCLES = clk_gate_pkg::BIAS_CYCLES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CLOCK_POWER_GOOD,
  input wire logic CPU_CLOCK_HALT_N,
  input wire logic STRAP,
  input wire logic [N_CPU-1:0] CPU_STOPPABLE,
  input wire logic [N_CPU-1:0] CPU_ENABLE,
  input wire logic [N_SE-1:0] SE_ENABLE,
  output logic [N_CPU-1:0] CPU_CLOCK_TRUE,
  output logic [N_CPU-1:0] CPU_CLOCK_COMPLEMENT,
  output logic [N_SE-1:0] SE_CLOCK,
  output logic SE_CLOCK_OE,
  output logic DIFF_BIAS_HIGH,
  output logic OSC_ENABLE
);

  // ***************************************************
  // Elaboration checks
  // ***************************************************
  if (N_CPU < 1 || N_SE < 1) begin : g_bad_width
    $error("At least one CPU pair and one single-ended clock required");
  end
  if (BIAS_CYCLES < 1 || LOCK_CYCLES <= BIAS_CYCLES || LOCK_CYCLES > 65535) begin : g_bad_cnt
    $error("Need 1 <= BIAS_CYCLES < LOCK_CYCLES <= 65535");
  end

  // ***************************************************
  // Declarations
  // ***************************************************
  clk_gate_pkg::state_e st;
  clk_gate_pkg::state_e next_st;
  logic pg_s1, pg_s2;
  logic halt_s1, halt_s2;
  logic strap_s1, strap_s2, strap_lat;
  logic ph;
  logic [1:0] se_cnt;
  logic se_gate;
  logic [1:0] pd_cnt;
  logic [1:0] halt_cnt;
  logic [15:0] cnt;
  logic [N_CPU-1:0] stop_flag;
  logic [N_CPU-1:0] next_stop;
  wire run_ok = (st == clk_gate_pkg::ST_RUN);
  wire rise = OSC_ENABLE & ~ph;
  wire crise = OSC_ENABLE & ph;
  wire pd_req = (pd_cnt == clk_gate_pkg::PD_SAMPLES);
  wire halt_req = (halt_cnt == clk_gate_pkg::HALT_SAMPLES);
  wire [1:0] next_se_cnt = OSC_ENABLE ? se_cnt + 2'h1 : se_cnt;
  wire next_se_val = next_se_cnt[1];
  wire lock_done = (cnt == 16'(LOCK_CYCLES - 1));
  wire hold_done = ~se_gate & (cnt[3:0] >= clk_gate_pkg::HOLD_CYCLES);
  wire next_osc = (next_st == clk_gate_pkg::ST_LOCK) | (next_st == clk_gate_pkg::ST_RUN)
                  | (next_st == clk_gate_pkg::ST_HOLD);
  wire next_bias = run_ok | ((st == clk_gate_pkg::ST_LOCK) & (cnt >= 16'(BIAS_CYCLES - 1)));
  // SE gate opens and closes only on a low phase, so no SE pulse is cut
  wire next_se_gate = next_se_val ? se_gate : run_ok;

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  // Two flops on every pin before any logic reads it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pg_s1 <= 1'b0;
      pg_s2 <= 1'b0;
      halt_s1 <= 1'b1;
      halt_s2 <= 1'b1;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      pg_s1 <= CLOCK_POWER_GOOD;
      pg_s2 <= pg_s1;
      halt_s1 <= CPU_CLOCK_HALT_N;
      halt_s2 <= halt_s1;
      strap_s1 <= STRAP;
      strap_s2 <= strap_s1;
    end
  end

  // Strap is caught while waiting for power good
  // Later strap changes are ignored, so the pin may be reused after boot
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_lat <= 1'b0;
    end else if (st == clk_gate_pkg::ST_WAIT_GOOD) begin
      strap_lat <= strap_s2;
    end
  end

  // ***************************************************
  // Internal clock phases
  // ***************************************************
  // CPU phase toggles and SE divider counts while the oscillator runs
  // Phase restarts at zero so each lock begins on a true rising edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ph <= 1'b0;
      se_cnt <= clk_gate_pkg::COUNT2_RESET;
      se_gate <= 1'b0;
    end else begin
      ph <= OSC_ENABLE ? ~ph : 1'b0;
      se_cnt <= next_se_cnt;
      se_gate <= next_se_gate;
    end
  end

  // ***************************************************
  // Sample counters
  // ***************************************************
  // Power down counted on CPU rising edges, halt on complement rising edges
  // Both counters saturate at two so a long low never wraps
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pd_cnt <= clk_gate_pkg::COUNT2_RESET;
      halt_cnt <= clk_gate_pkg::COUNT2_RESET;
    end else begin
      if (pg_s2 || !run_ok) begin
        pd_cnt <= clk_gate_pkg::COUNT2_RESET;
      end else if (rise && !pd_req) begin
        pd_cnt <= pd_cnt + 2'h1;
      end
      if (halt_s2) begin
        halt_cnt <= clk_gate_pkg::COUNT2_RESET;
      end else if (crise && !halt_req) begin
        halt_cnt <= halt_cnt + 2'h1;
      end
    end
  end

  // ***************************************************
  // Power state machine
  // ***************************************************
  // Next state from synced pin, lock and hold counters
  always_comb begin
    next_st = st;
    case (st)
      clk_gate_pkg::ST_WAIT_GOOD: begin
        if (pg_s2) begin
          next_st = clk_gate_pkg::ST_LOCK;
        end
      end
      clk_gate_pkg::ST_LOCK: begin
        if (!pg_s2) begin
          next_st = clk_gate_pkg::ST_OFF;
        end else if (lock_done) begin
          next_st = clk_gate_pkg::ST_RUN;
        end
      end
      clk_gate_pkg::ST_RUN: begin
        if (pd_req) begin
          next_st = clk_gate_pkg::ST_HOLD;
        end
      end
      clk_gate_pkg::ST_HOLD: begin
        if (hold_done) begin
          next_st = clk_gate_pkg::ST_OFF;
        end
      end
      clk_gate_pkg::ST_OFF: begin
        if (pg_s2) begin
          next_st = clk_gate_pkg::ST_LOCK;
        end
      end
      default: next_st = clk_gate_pkg::ST_WAIT_GOOD;
    endcase
  end

  // State, shared counter, oscillator and bias flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= clk_gate_pkg::ST_WAIT_GOOD;
      cnt <= clk_gate_pkg::COUNT16_RESET;
      OSC_ENABLE <= 1'b0;
      DIFF_BIAS_HIGH <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= (next_st != st) ? clk_gate_pkg::COUNT16_RESET : cnt + 16'h0001;
      OSC_ENABLE <= next_osc;
      DIFF_BIAS_HIGH <= next_bias;
    end
  end

  // ***************************************************
  // CPU pairs
  // ***************************************************
  // Park on a true rising edge, release on a true falling edge
  // Set and clear fall on opposite phases, so they never meet in one cycle
  for (genvar i = 0; i < N_CPU; i++) begin : g_cpu
    assign next_stop[i] = !run_ok ? 1'b0
                        : (halt_req && CPU_STOPPABLE[i] && rise) ? 1'b1
                        : (halt_s2 && crise) ? 1'b0
                        : stop_flag[i];

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        stop_flag[i] <= 1'b0;
        CPU_CLOCK_TRUE[i] <= 1'b0;
        CPU_CLOCK_COMPLEMENT[i] <= 1'b0;
      end else begin
        stop_flag[i] <= next_stop[i];
        // Low outside run or when disabled; parked high/low when stopped
        CPU_CLOCK_TRUE[i] <= run_ok & CPU_ENABLE[i] & (next_stop[i] | ~ph);
        CPU_CLOCK_COMPLEMENT[i] <= run_ok & CPU_ENABLE[i] & ~next_stop[i] & ph;
      end
    end
  end

  // ***************************************************
  // Single-ended clocks
  // ***************************************************
  // SE clocks ignore halt; hi-z in power down only when strapped
  for (genvar j = 0; j < N_SE; j++) begin : g_se
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        SE_CLOCK[j] <= 1'b0;
      end else begin
        SE_CLOCK[j] <= next_se_gate & SE_ENABLE[j] & next_se_val;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      SE_CLOCK_OE <= 1'b1;
    end else begin
      SE_CLOCK_OE <= ~(strap_lat & (next_st == clk_gate_pkg::ST_OFF));
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  good_first_a: assert property (
    ($past(st) == clk_gate_pkg::ST_WAIT_GOOD) && (st != clk_gate_pkg::ST_WAIT_GOOD)
    |-> $past(pg_s2)) else $error("Left power-good wait without good");

  pd_two_samples_a: assert property (
    $rose(st == clk_gate_pkg::ST_HOLD) |-> !pg_s2 && $past(pd_cnt) == 2'h2)
    else $error("Power down entered without two low samples");

  diff_low_pd_a: assert property (
    (st != clk_gate_pkg::ST_RUN) |=> (CPU_CLOCK_TRUE == '0) && (CPU_CLOCK_COMPLEMENT == '0))
    else $error("CPU pair not low outside run");

  hold_parks_se_a: assert property (
    (st == clk_gate_pkg::ST_HOLD) [*5] |-> (SE_CLOCK == '0))
    else $error("SE clocks not parked in hold");

  osc_after_low_a: assert property (
    $fell(OSC_ENABLE) |-> $past(SE_CLOCK == '0) && $past(CPU_CLOCK_TRUE == '0))
    else $error("Oscillator stopped before outputs low");

  strap_hiz_a: assert property (
    (st == clk_gate_pkg::ST_OFF) |-> (SE_CLOCK_OE == !strap_lat) && (SE_CLOCK == '0))
    else $error("Wrong SE drive in power down");

  lock_bound_a: assert property (
    (st == clk_gate_pkg::ST_LOCK) |-> (cnt < 16'(LOCK_CYCLES)))
    else $error("Lock wait too long");

  bias_high_a: assert property (
    (st == clk_gate_pkg::ST_LOCK) && (cnt == 16'(BIAS_CYCLES)) |-> DIFF_BIAS_HIGH)
    else $error("Bias not raised in time");

  // Park follows the second complement sample at the next true rising edge
  halt_parks_a: assert property (
    $rose(halt_req) && run_ok && CPU_STOPPABLE[0] && CPU_ENABLE[0]
    |=> (CPU_CLOCK_TRUE[0] && !CPU_CLOCK_COMPLEMENT[0]) || !run_ok)
    else $error("Stoppable pair not parked");

  nonstop_runs_a: assert property (
    run_ok && $past(run_ok) && !CPU_STOPPABLE[0] && CPU_ENABLE[0] && $past(CPU_ENABLE[0])
    |=> CPU_CLOCK_TRUE[0] != $past(CPU_CLOCK_TRUE[0]))
    else $error("Non-stoppable pair not toggling");

  restart_lat_a: assert property (
    $rose(halt_s2) && run_ok |-> ##[1:2] (!stop_flag[0] || !run_ok))
    else $error("Restart too slow");

  disabled_low_a: assert property (
    !CPU_ENABLE[0] |=> !CPU_CLOCK_TRUE[0]) else $error("Disabled pair not low");

  // Restart lands on the low half, so the first true pulse is a full one
  restart_clean_a: assert property (
    $fell(stop_flag[0]) && run_ok && CPU_ENABLE[0]
    |-> !CPU_CLOCK_TRUE[0] && CPU_CLOCK_COMPLEMENT[0] ##1 (CPU_CLOCK_TRUE[0] || !run_ok))
    else $error("Restart pulse cut or stretched");

  wake_lock_a: assert property (
    (st == clk_gate_pkg::ST_OFF) && pg_s2 |=> (st == clk_gate_pkg::ST_LOCK))
    else $error("Power-down release did not wake");

  hold_exit_a: assert property (
    (st == clk_gate_pkg::ST_HOLD)
    |=> (st == clk_gate_pkg::ST_HOLD) || (st == clk_gate_pkg::ST_OFF))
    else $error("Hold left other than to power down");

  drive_on_a: assert property (
    (st != clk_gate_pkg::ST_OFF) |-> SE_CLOCK_OE)
    else $error("SE drive off outside power down");

  bias_off_a: assert property (
    (st == clk_gate_pkg::ST_OFF) |=> !DIFF_BIAS_HIGH)
    else $error("Bias left high in power down");

  halt_cv: cover property (run_ok && stop_flag[0] ##[1:20] !stop_flag[0]);
  pd_cv: cover property ((st == clk_gate_pkg::ST_HOLD) ##[1:20] (st == clk_gate_pkg::ST_OFF));
  wake_cv: cover property ((st == clk_gate_pkg::ST_OFF) ##[1:10] (st == clk_gate_pkg::ST_LOCK));
  park_cv: cover property (stop_flag[0] && CPU_CLOCK_TRUE[0] && !CPU_CLOCK_COMPLEMENT[0]);
  boot_off_cv: cover property ((st == clk_gate_pkg::ST_LOCK) ##1 (st == clk_gate_pkg::ST_OFF));

endmodule

`default_nettype wire

// file: src/clk_gate_pkg.sv
// Purpose: Shared constants and state codes for the clock power-down and CPU halt block.
// Assumes: CLK runs at 20 MHz; internal CPU clock is CLK/2, single-ended clock CLK/4.
// Notes: Long cycle counts are also top-level parameters so simulation can shorten them.

package clk_gate_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int POWERUP_LATENCY_NS = 1800000;
  localparam int BIAS_LATENCY_NS = 300000;
  // Window the controller has to pull the pin low after power good
  localparam int GOOD_TO_PD_NS = 10000;
  localparam int ENABLE_MARGIN = 8;
  // Longest times round down; a strict "less than" takes one cycle off
  localparam int POWERUP_CYCLES = POWERUP_LATENCY_NS / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES = POWERUP_CYCLES - ENABLE_MARGIN;
  localparam int BIAS_CYCLES = (BIAS_LATENCY_NS / CLK_PERIOD_NS) - 1;

  // ***************************************************
  // Counts and reset values
  // ***************************************************
  localparam logic [1:0] PD_SAMPLES = 2'h2;
  localparam logic [1:0] HALT_SAMPLES = 2'h2;
  localparam logic [3:0] HOLD_CYCLES = 4'h8;
  localparam logic [1:0] COUNT2_RESET = 2'h0;
  localparam logic [15:0] COUNT16_RESET = 16'h0000;

  // ***************************************************
  // Power state machine
  // ***************************************************
  typedef enum logic [4:0] {
    ST_WAIT_GOOD = 5'b00001,
    ST_LOCK = 5'b00010,
    ST_RUN = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_OFF = 5'b10000
  } state_e;

endpackage

// file: bench/power_ctrl_model.sv
// Purpose: Platform power controller driving the power good and CPU halt pins.
// Assumes: Pins are levels that may change at any time; here just after a falling edge.
// Notes: Boot with boot_off pulls the pin low again to start powered down.

`timescale 1ns/1ps
`default_nettype none

module power_ctrl_model (
  input wire logic clk,
  output logic power_good,
  output logic halt_n
);
  initial begin
    power_good = 1'b0;
    halt_n = 1'b1;
  end

  // Pin levels move away from the sampling edge
  task automatic drive_good(input logic v);
    @(negedge clk);
    power_good = v;
  endtask

  task automatic drive_halt(input logic v);
    @(negedge clk);
    halt_n = v;
  endtask

  // Gap of at most 30 cycles, far under 10 us
  task automatic boot_off();
    int gap;
    gap = $urandom_range(1, 30);
    drive_good(1'b1);
    repeat (gap) @(negedge clk);
    power_good = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: bench/clock_power_down_and_cpu_stop_bench.sv
// Purpose: Self-checking bench for power down and CPU halt gating.
// Assumes: Lock count shortened to 40, bias count to 10.
// Notes: Toggle counts per window stand in for the expected waveform.

`timescale 1ns/1ps
`default_nettype none

module clock_power_down_and_cpu_stop_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b1;
  logic [1:0] stop_mask = 2'h0;
  logic [1:0] cpu_en = 2'h3;
  logic [1:0] se_en = 2'h3;
  wire logic pg;
  wire logic halt_n;
  logic [1:0] ct;
  logic [1:0] cc;
  logic [1:0] se;
  logic se_oe;
  logic bias;
  logic osc;
  int n_fail = 0;
  int n_tests = 0;
  int tog[6];

  always #25 clk = ~clk;

  power_ctrl_model partner (.clk(clk), .power_good(pg), .halt_n(halt_n));

  clock_power_down_and_cpu_stop #(.LOCK_CYCLES(40), .BIAS_CYCLES(10)) dut (
    .CLK(clk), .RESETN(resetn), .CLOCK_POWER_GOOD(pg), .CPU_CLOCK_HALT_N(halt_n),
    .STRAP(strap), .CPU_STOPPABLE(stop_mask), .CPU_ENABLE(cpu_en), .SE_ENABLE(se_en),
    .CPU_CLOCK_TRUE(ct), .CPU_CLOCK_COMPLEMENT(cc), .SE_CLOCK(se), .SE_CLOCK_OE(se_oe),
    .DIFF_BIAS_HIGH(bias), .OSC_ENABLE(osc));

  // ***************************************************
  // Shared tasks
  // ***************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Count level changes of each clock output over a number of cycles
  task automatic watch(input int cycles);
    logic [5:0] last;
    logic [5:0] now;
    tog = '{default: 0};
    @(negedge clk);
    last = {se, cc, ct};
    repeat (cycles) begin
      @(negedge clk);
      now = {se, cc, ct};
      for (int i = 0; i < 6; i++) if (now[i] !== last[i]) tog[i]++;
      last = now;
    end
  endtask

  task automatic power_up();
    int n;
    n = 0;
    partner.drive_good(1'b1);
    while (osc !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    check("osc_on", osc, 1'b1);
    check("bias_lock", bias, 1'b0);
    while (ct === 2'h0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check("bias_run", bias, 1'b1);
    check("lock_time", n >= 38 && n <= 46, 1'b1);
    watch(8);
    check("run_cpu", tog[0] + tog[1] + tog[2] + tog[3], 32);
    check("run_se", tog[4] + tog[5], 8);
    $display("test power up done");
  endtask

  task automatic power_down(input logic strap_set);
    int n;
    n = 0;
    partner.drive_good(1'b0);
    repeat (14) @(negedge clk);
    check("pd_outs", {ct, cc, se}, 6'h00);
    while (osc !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("osc_off", osc, 1'b0);
    check("pd_oe", se_oe, !strap_set);
    check("off_outs", {ct, cc, se, bias}, 7'h00);
    $display("test power down done");
  endtask

  task automatic halt_test(input logic [1:0] mask);
    stop_mask = mask;
    partner.drive_halt(1'b0);
    watch(3);
    check("halt_early", tog[0] + tog[1], 6);
    repeat (12) @(negedge clk);
    watch(8);
    for (int i = 0; i < 2; i++) begin
      check("park_tog", tog[i], mask[i] ? 0 : 8);
      if (mask[i]) check("park_lvl", {ct[i], cc[i]}, 2'h2);
    end
    check("se_halt", tog[4] + tog[5], 8);
    partner.drive_halt(1'b1);
    repeat (6) @(negedge clk);
    watch(8);
    check("resume", tog[0] + tog[1] + tog[2] + tog[3], 32);
    check("sync", {ct, cc}, {ct[1], ct[1], ~ct[1], ~ct[1]});
    $display("test halt mask %0h done", mask);
  endtask

  task automatic wrap_up();
    $display("counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    logic [1:0] m;
    void'($urandom(62107));
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    check("wait_good", {osc, ct, cc, se, se_oe}, 8'h01);
    power_up();
    m = 2'($urandom_range(1, 2));
    halt_test(m);
    halt_test(~m);
    cpu_en = 2'($urandom_range(1, 2));
    se_en = ~cpu_en;
    repeat (4) @(negedge clk);
    watch(8);
    for (int i = 0; i < 2; i++) begin
      check("cpu_en_tog", tog[i] + tog[i+2], cpu_en[i] ? 16 : 0);
      check("se_en_tog", tog[4+i], se_en[i] ? 4 : 0);
      if (!cpu_en[i]) check("dis_lvl", {ct[i], cc[i]}, 2'h0);
      if (!se_en[i]) check("se_dis_lvl", se[i], 1'b0);
    end
    cpu_en = 2'h3;
    se_en = 2'h3;
    power_down(1'b1);
    power_up();
    power_down(1'b1);
    resetn = 1'b0;
    strap = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    partner.boot_off();
    repeat (60) @(negedge clk);
    check("boot_off", {osc, ct, cc, se, se_oe}, 8'h01);
    $display("test boot powered down done");
    wrap_up();
  end

  // Watchdog far beyond the expected run of about 350 cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule

`default_nettype wire
